// *** rtl/stc_map.svh ***
// Purpose: offsets, field positions, reset values and counts of switch timing and capture
// Assumes: 32-bit APB, one register per aligned word
// Notes: included by the package and the main module
// What this block does
// - switch starts each cycle at programmed level
// - up to four switch changes per even half
// - odd half repeats the even pattern
// - clocks per sensor sets return interval
// - change at sensor start plus clock offset
// - change given as sensor index plus clocks
// - raw samples captured every 50MHz clock
// - source is receiver 0, 1, 2 or sum/2
// - capture length in whole modulation cycles
// - single-pulse mode fires one pulse only
// - samples carry overflow, pulse, slope flags
// - capture starts at first strobe offset
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

`define STC_OFS_CTRL 8'h00
`define STC_OFS_CLK_PER_SENSOR 8'h04
`define STC_OFS_CYCLES 8'h08
`define STC_OFS_STROBE_OFS 8'h0C
`define STC_OFS_SWITCH0 8'h10
`define STC_OFS_STATUS 8'h20
`define STC_OFS_DATA 8'h24

`define STC_CTRL_START_LEVEL 0
`define STC_CTRL_SINGLE 1
`define STC_CTRL_GO 2
`define STC_CTRL_SRC_LO 4
`define STC_CTRL_SRC_HI 5

`define STC_SW_EN 31
`define STC_SW_SENS_LO 16
`define STC_SW_SENS_HI 23
`define STC_SW_CLK_HI 15

`define STC_ST_BUSY 0
`define STC_ST_OVERRUN 1
`define STC_ST_VALID 2

`define STC_WORD_OVF 16
`define STC_WORD_PULSE 17
`define STC_WORD_SLOPE 18

`define STC_RST_CLK_PER_SENSOR 16'h0004
`define STC_RST_CYCLES 16'h0001
`define STC_RST_STROBE_OFS 16'h0000

`define STC_NUM_SWITCH 4
`define STC_ADC_W 14

`endif

// *** rtl/stc_pkg.sv ***
// Purpose: types of the switch timing and capture block
// Assumes: stc_map.svh holds the numbers
// Notes: none
`default_nettype none
`include "stc_map.svh"

package stc_pkg;

    typedef enum logic [1:0] {
        STC_SRC_RX0 = 2'b00,
        STC_SRC_RX1 = 2'b01,
        STC_SRC_RX2 = 2'b10,
        STC_SRC_SUM = 2'b11
    } stc_src_t;

    typedef enum logic [1:0] {
        STC_CAP_IDLE = 2'b00,
        STC_CAP_WAIT = 2'b01,
        STC_CAP_RUN = 2'b10
    } stc_cap_t;

endpackage : stc_pkg

`default_nettype wire

// *** rtl/stc_buf.sv ***
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, reads come from a register
// Notes: in_ready low when both entries are held
`timescale 1ns/1ps
`default_nettype none

module stc_buf (
    input wire logic core_clk, // master clock
    input wire logic rst_b, // async reset, active low
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [31:0] in_data, // word in
    output logic out_valid, // word available
    input wire logic out_ready, // word taken
    output logic [31:0] out_data // head word, registered
);
    logic [31:0] hold_q;
    logic [1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 2'd0;
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // head is out_data; second entry sits in hold_q
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_data <= 32'h0;
            hold_q <= 32'h0;
        end else begin
            if (pop) begin
                out_data <= (cnt_q == 2'd2) ? hold_q : in_data;
            end else if (push && cnt_q == 2'd0) begin
                out_data <= in_data;
            end
            if (push && ((cnt_q == 2'd1 && !pop) || cnt_q == 2'd2)) begin
                hold_q <= in_data;
            end
        end
    end

endmodule : stc_buf

`default_nettype wire

// *** rtl/stc_top.sv ***
// Purpose: switch output locked to sensor returns, and raw receiver capture
// Assumes: mod_even_start/mod_odd_start are one-cycle pulses from the timing table
// Notes: capture words are read through the data register, each read pops one
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"

module stc_top
    import stc_pkg::*;
(
    input wire logic core_clk, // 50 MHz master clock
    input wire logic rst_b, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic mod_even_start, // start of modulation cycle, even half
    input wire logic mod_odd_start, // start of odd half
    input wire logic pulse_req, // pulse request from timing table
    output logic pulse_out, // gated optical pulse
    output logic switch_out, // programmable switch line
    output logic first_strobe_out, // first sample strobe of the cycle
    input wire logic [13:0] receiver_zero_channel, // receiver 0 sample
    input wire logic [13:0] receiver_one_channel, // receiver 1 sample
    input wire logic [13:0] receiver_two_channel, // receiver 2 sample
    input wire logic [2:0] rx_ovf // converter overflow per receiver
);
    localparam int NSW = `STC_NUM_SWITCH;

    // host registers
    logic [31:0] ctrl_q;
    logic [15:0] cps_q, cycles_q, first_strobe_offset_q;
    logic [31:0] sw_q [NSW];
    logic overrun_q;
    logic [31:0] prdata_q;

    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire sel_ctrl = (paddr == `STC_OFS_CTRL);
    wire sel_cps = (paddr == `STC_OFS_CLK_PER_SENSOR);
    wire sel_cyc = (paddr == `STC_OFS_CYCLES);
    wire sel_sofs = (paddr == `STC_OFS_STROBE_OFS);
    wire sel_sw = (paddr[7:4] == 4'h1) && (paddr[1:0] == 2'b00);
    wire [1:0] sw_idx = paddr[3:2];
    wire sel_stat = (paddr == `STC_OFS_STATUS);
    wire sel_data = (paddr == `STC_OFS_DATA);
    wire mapped = sel_ctrl | sel_cps | sel_cyc | sel_sofs | sel_sw | sel_stat | sel_data;
    wire go = wr && sel_ctrl && pwdata[`STC_CTRL_GO];
    wire start_level = ctrl_q[`STC_CTRL_START_LEVEL];
    wire single_mode = ctrl_q[`STC_CTRL_SINGLE];
    wire [1:0] src_sel = ctrl_q[`STC_CTRL_SRC_HI:`STC_CTRL_SRC_LO];

    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 32'h0;
            cps_q <= `STC_RST_CLK_PER_SENSOR;
            cycles_q <= `STC_RST_CYCLES;
            first_strobe_offset_q <= `STC_RST_STROBE_OFS;
        end else if (wr) begin
            if (sel_ctrl) ctrl_q <= pwdata & 32'h0000_0033;
            if (sel_cps) cps_q <= pwdata[15:0];
            if (sel_cyc) cycles_q <= pwdata[15:0];
            if (sel_sofs) first_strobe_offset_q <= pwdata[15:0];
        end
    end

    // switch timing
    logic [15:0] clk_cnt_q;
    logic [7:0] sens_q;
    logic switch_q;
    logic [NSW-1:0] hit;
    wire half_start = mod_even_start || mod_odd_start;
    wire sens_end = (clk_cnt_q >= cps_q - 16'd1);
    wire [15:0] clk_now = half_start ? 16'h0 : (sens_end ? 16'h0 : clk_cnt_q + 16'd1);
    wire [7:0] sens_now = half_start ? 8'h0 : (sens_end ? sens_q + 8'd1 : sens_q);

    genvar gi;
    generate
        for (gi = 0; gi < NSW; gi++) begin : g_sw
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sw_q[gi] <= 32'h0;
                end else if (wr && sel_sw && sw_idx == 2'(gi)) begin
                    sw_q[gi] <= pwdata & 32'h80FF_FFFF;
                end
            end
            // change when the slot position matches sensor index and clock offset
            assign hit[gi] = sw_q[gi][`STC_SW_EN]
                && (sw_q[gi][`STC_SW_SENS_HI:`STC_SW_SENS_LO] == sens_now)
                && (sw_q[gi][`STC_SW_CLK_HI:0] == clk_now);
        end
    endgenerate

    wire any_toggle = ^hit;
    // each half restarts from the start level, so the odd half replays the pattern
    wire switch_base = half_start ? start_level : switch_q;
    wire switch_d = switch_base ^ any_toggle;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_cnt_q <= 16'h0;
            sens_q <= 8'h0;
            switch_q <= 1'b0;
        end else begin
            clk_cnt_q <= clk_now;
            sens_q <= sens_now;
            switch_q <= switch_d;
        end
    end
    assign switch_out = switch_q;

    // first strobe and slope
    logic [15:0] strobe_cnt_q;
    logic strobe_run_q, strobe_q, odd_q;
    wire strobe_hit = strobe_run_q && (strobe_cnt_q == first_strobe_offset_q);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_cnt_q <= 16'h0;
            strobe_run_q <= 1'b0;
            strobe_q <= 1'b0;
            odd_q <= 1'b0;
        end else begin
            strobe_q <= strobe_hit;
            if (mod_even_start) begin
                strobe_cnt_q <= 16'h0;
                strobe_run_q <= 1'b1;
            end else if (strobe_hit) begin
                strobe_run_q <= 1'b0;
            end else if (strobe_run_q) begin
                strobe_cnt_q <= strobe_cnt_q + 16'd1;
            end
            if (mod_even_start) odd_q <= 1'b0;
            else if (mod_odd_start) odd_q <= 1'b1;
        end
    end
    assign first_strobe_out = strobe_q;

    // pulse gating
    logic pulse_used_q, pulse_q;
    wire pulse_ok = pulse_req && (!single_mode || !pulse_used_q);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_used_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= pulse_ok;
            if (go) pulse_used_q <= 1'b0;
            else if (pulse_ok && single_mode) pulse_used_q <= 1'b1;
        end
    end
    assign pulse_out = pulse_q;

    // capture
    stc_cap_t cap_q;
    logic [15:0] left_q;
    logic [14:0] sample;
    logic ovf;
    wire [15:0] rx_sum = 16'(receiver_zero_channel) + 16'(receiver_one_channel)
        + 16'(receiver_two_channel);

    always_comb begin
        case (stc_src_t'(src_sel))
            STC_SRC_RX0: begin
                sample = 15'(receiver_zero_channel);
                ovf = rx_ovf[0];
            end
            STC_SRC_RX1: begin
                sample = 15'(receiver_one_channel);
                ovf = rx_ovf[1];
            end
            STC_SRC_RX2: begin
                sample = 15'(receiver_two_channel);
                ovf = rx_ovf[2];
            end
            default: begin
                sample = rx_sum[15:1];
                ovf = |rx_ovf;
            end
        endcase
    end

    wire cap_last = strobe_hit && (left_q <= 16'd1);
    wire cap_take = (cap_q == STC_CAP_RUN && !cap_last)
        || (cap_q == STC_CAP_WAIT && strobe_hit && cycles_q != 16'h0);
    wire [31:0] cap_word = {13'h0, odd_q, pulse_q, ovf, 1'b0, sample};
    logic buf_in_ready, buf_out_valid;
    logic [31:0] buf_out_data;
    wire pop = access && !pwrite && sel_data && buf_out_valid;

    stc_buf u_buf (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(cap_take),
        .in_ready(buf_in_ready),
        .in_data(cap_word),
        .out_valid(buf_out_valid),
        .out_ready(pop),
        .out_data(buf_out_data)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cap_q <= STC_CAP_IDLE;
            left_q <= 16'h0;
        end else begin
            case (cap_q)
                STC_CAP_IDLE: begin
                    if (go) begin
                        cap_q <= STC_CAP_WAIT;
                        left_q <= cycles_q;
                    end
                end
                STC_CAP_WAIT: begin
                    if (strobe_hit) begin
                        cap_q <= (cycles_q == 16'h0) ? STC_CAP_IDLE : STC_CAP_RUN;
                    end
                end
                STC_CAP_RUN: begin
                    if (cap_last) begin
                        cap_q <= STC_CAP_IDLE;
                    end else if (strobe_hit) begin
                        left_q <= left_q - 16'd1;
                    end
                end
                default: cap_q <= STC_CAP_IDLE;
            endcase
        end
    end

    // overrun: a sample lost to a full buffer; set wins over the clear
    wire ovr_clr = wr && sel_stat && pwdata[`STC_ST_OVERRUN];
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            overrun_q <= 1'b0;
        end else if (cap_take && !buf_in_ready) begin
            overrun_q <= 1'b1;
        end else if (ovr_clr) begin
            overrun_q <= 1'b0;
        end
    end

    wire [31:0] stat_word = {29'h0, buf_out_valid, overrun_q, cap_q != STC_CAP_IDLE};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_q
        : sel_cps ? {16'h0, cps_q}
        : sel_cyc ? {16'h0, cycles_q}
        : sel_sofs ? {16'h0, first_strobe_offset_q}
        : sel_sw ? sw_q[sw_idx]
        : sel_stat ? stat_word
        : sel_data ? buf_out_data
        : 32'h0;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0;
        end else if (setup) begin
            prdata_q <= rd_mux;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    level_start_a: assert property (
        mod_even_start && !any_toggle |=> switch_out == $past(start_level))
        else $error("switch not at start level at cycle start");
    switch_toggle_a: assert property (
        !half_start && any_toggle |=> switch_out != $past(switch_out))
        else $error("programmed switch change missed");
    odd_repeat_a: assert property (
        mod_odd_start && !any_toggle |=> switch_out == $past(start_level))
        else $error("odd half did not restart pattern");
    sensor_wrap_a: assert property (
        !half_start && sens_end |=> clk_cnt_q == 16'h0 && sens_q == $past(sens_q) + 8'd1)
        else $error("sensor slot did not advance");
    switch_hold_a: assert property (
        !half_start && !any_toggle |=> $stable(switch_out))
        else $error("switch changed without a programmed hit");
    cap_take_a: assert property (
        cap_q == STC_CAP_RUN && !strobe_hit && buf_in_ready |=> buf_out_valid)
        else $error("capture skipped a clock");
    sum_src_a: assert property (
        src_sel == 2'b11 |-> cap_word[14:0] == 15'((17'(receiver_zero_channel)
        + 17'(receiver_one_channel) + 17'(receiver_two_channel)) >> 1))
        else $error("sum source not halved sum");
    cap_end_a: assert property (
        cap_q == STC_CAP_RUN && cap_last |=> cap_q == STC_CAP_IDLE)
        else $error("capture ran past programmed cycles");
    single_pulse_a: assert property (
        single_mode && pulse_used_q && !go |=> !pulse_out)
        else $error("second pulse in single-pulse mode");
    flag_bits_a: assert property (
        cap_take |-> cap_word[`STC_WORD_SLOPE] == odd_q
        && cap_word[`STC_WORD_PULSE] == pulse_out)
        else $error("sample flags wrong");
    first_sample_a: assert property (
        cap_q == STC_CAP_WAIT && cycles_q != 16'h0 |-> cap_take == strobe_hit)
        else $error("capture not started at first strobe");

endmodule : stc_top

`default_nettype wire

// *** tb/stc_far_model.sv ***
// Purpose: far-side timing table and receivers for the switch timing and capture bench
// Assumes: modulation cycle of 32 master clocks, two halves of 16
// Notes: receivers hold fixed levels so each capture source gives a known word
`timescale 1ns/1ps
`default_nettype none

module stc_far_model (
    input wire logic core_clk, // master clock
    input wire logic rst_b, // async reset, active low
    output logic [4:0] ph, // position within the modulation cycle
    output logic mod_even_start, // even half begins
    output logic mod_odd_start, // odd half begins
    output logic pulse_req, // one request per cycle
    output logic [13:0] receiver_zero_channel, // receiver 0 level
    output logic [13:0] receiver_one_channel, // receiver 1 level
    output logic [13:0] receiver_two_channel, // receiver 2 level
    output logic [2:0] rx_ovf // only receiver 1 saturated
);
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ph <= 5'h00;
        end else begin
            ph <= ph + 5'h01;
        end
    end
    assign mod_even_start = rst_b && (ph == 5'h00);
    assign mod_odd_start = rst_b && (ph == 5'h10);
    // request sits in the odd half so early capture words carry no pulse flag
    assign pulse_req = rst_b && (ph == 5'h14);
    assign receiver_zero_channel = 14'h0123;
    assign receiver_one_channel = 14'h0456;
    assign receiver_two_channel = 14'h0789;
    assign rx_ovf = 3'h2;
endmodule : stc_far_model
`default_nettype wire

// *** tb/stc_top_tb.sv ***
// Purpose: self-checking bench of the switch timing and capture block
// Assumes: far model cycle of 32 clocks, zero-wait APB
// Notes: capture rows in a table, switch, pulse, length and reset by hand
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"

module stc_top_tb
    import stc_pkg::*;
;
    typedef struct packed {
        logic [1:0] src;
        logic [31:0] word;
    } stc_tb_row_t;
    localparam int LIMIT = 20000;
    logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mod_even_start, mod_odd_start, pulse_req, pulse_out, switch_out, first_strobe_out;
    logic [13:0] receiver_zero_channel, receiver_one_channel, receiver_two_channel;
    logic [2:0] rx_ovf;
    logic [4:0] ph;
    logic e;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycle_cnt = 0;
    int cnt;
    stc_tb_row_t rows [4];
    int slot [4] = '{1, 3, 7, 13};
    logic [31:0] sw [4] = '{32'h8000_0001, 32'h8000_0003, 32'h8001_0002, 32'h8002_0003};
    logic [7:0] radr [6] = '{`STC_OFS_CTRL, `STC_OFS_CLK_PER_SENSOR, `STC_OFS_CYCLES,
        `STC_OFS_STROBE_OFS, `STC_OFS_SWITCH0, `STC_OFS_STATUS};
    logic [31:0] rval [6] = '{32'h0, 32'h4, 32'h1, 32'h0, 32'h0, 32'h0};

    stc_top DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mod_even_start(mod_even_start), .mod_odd_start(mod_odd_start),
        .pulse_req(pulse_req), .pulse_out(pulse_out), .switch_out(switch_out),
        .first_strobe_out(first_strobe_out), .receiver_zero_channel(receiver_zero_channel),
        .receiver_one_channel(receiver_one_channel),
        .receiver_two_channel(receiver_two_channel), .rx_ovf(rx_ovf));
    stc_far_model far (.core_clk(core_clk), .rst_b(rst_b), .ph(ph),
        .mod_even_start(mod_even_start), .mod_odd_start(mod_odd_start), .pulse_req(pulse_req),
        .receiver_zero_channel(receiver_zero_channel), .receiver_one_channel(receiver_one_channel),
        .receiver_two_channel(receiver_two_channel), .rx_ovf(rx_ovf));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        chk("pready", 32'(pready), 32'h0000_0001);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_ph(input logic [4:0] p);
        do @(negedge core_clk); while (ph !== p);
    endtask : wait_ph

    task automatic count_pulses();
        cnt = 0;
        repeat (96) begin
            @(negedge core_clk);
            if (pulse_out === 1'b1) begin
                cnt++;
                chk("pulse_out phase", 32'(ph), 32'h0000_0015);
            end
        end
    endtask : count_pulses

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycle_cnt++;
        if (cycle_cnt == LIMIT) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rows = '{'{2'h0, 32'h0000_0123}, '{2'h1, 32'h0001_0456},
            '{2'h2, 32'h0000_0789}, '{2'h3, 32'h0001_0681}};
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        apb(1'b1, `STC_OFS_STROBE_OFS, 32'h0000_0003);
        foreach (rows[i]) begin
            wait_ph(5'h18);
            apb(1'b1, `STC_OFS_CTRL, {26'h0, rows[i].src, 4'h4});
            do @(negedge core_clk); while (first_strobe_out !== 1'b1);
            chk("first strobe phase", 32'(ph), 32'h0000_0005);
            repeat (100) @(posedge core_clk);
            apb(1'b0, `STC_OFS_DATA, 32'h0);
            chk("word0", rd, rows[i].word);
            apb(1'b0, `STC_OFS_DATA, 32'h0);
            chk("word1", rd, rows[i].word);
            apb(1'b0, `STC_OFS_STATUS, 32'h0);
            chk("status after capture", rd, 32'h0000_0002);
            apb(1'b1, `STC_OFS_STATUS, 32'h0000_0002);
            apb(1'b0, `STC_OFS_STATUS, 32'h0);
            chk("status cleared", rd, 32'h0);
            $display("capture row %0d done", i);
        end
        apb(1'b1, `STC_OFS_STROBE_OFS, 32'h0000_0013);
        wait_ph(5'h18);
        apb(1'b1, `STC_OFS_CTRL, 32'h0000_0004);
        do @(negedge core_clk); while (first_strobe_out !== 1'b1);
        chk("late strobe phase", 32'(ph), 32'h0000_0015);
        repeat (100) @(posedge core_clk);
        apb(1'b0, `STC_OFS_DATA, 32'h0);
        chk("odd word0", rd, 32'h0004_0123);
        apb(1'b0, `STC_OFS_DATA, 32'h0);
        chk("odd word1", rd, 32'h0006_0123);
        $display("odd half capture done");
        apb(1'b1, `STC_OFS_CLK_PER_SENSOR, 32'h0000_0005);
        foreach (sw[i]) apb(1'b1, `STC_OFS_SWITCH0 + 8'(4 * i), sw[i]);
        for (int lvl = 0; lvl < 2; lvl++) begin
            apb(1'b1, `STC_OFS_CTRL, 32'(lvl));
            wait_ph(5'h00);
            for (int p = 1; p < 32; p++) begin
                @(negedge core_clk);
                e = 1'(lvl);
                foreach (slot[i]) if (slot[i] < p % 16) e = ~e;
                chk("switch_out", 32'(switch_out), 32'(e));
            end
        end
        $display("switch pattern done");
        wait_ph(5'h18);
        apb(1'b1, `STC_OFS_CTRL, 32'h0000_0006);
        count_pulses();
        chk("single pulse count", 32'(cnt), 32'h0000_0001);
        wait_ph(5'h18);
        apb(1'b1, `STC_OFS_CTRL, 32'h0000_0004);
        count_pulses();
        chk("pulse count", 32'(cnt), 32'h0000_0003);
        $display("pulse gating done");
        apb(1'b1, `STC_OFS_CYCLES, 32'h0000_0002);
        wait_ph(5'h18);
        apb(1'b1, `STC_OFS_CTRL, 32'h0000_0004);
        do @(negedge core_clk); while (first_strobe_out !== 1'b1);
        repeat (40) @(posedge core_clk);
        apb(1'b0, `STC_OFS_STATUS, 32'h0);
        chk("busy mid capture", rd & 32'h1, 32'h1);
        repeat (40) @(posedge core_clk);
        apb(1'b0, `STC_OFS_STATUS, 32'h0);
        chk("busy after capture", rd & 32'h1, 32'h0);
        $display("capture length done");
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (radr[i]) begin
            apb(1'b0, radr[i], 32'h0);
            chk("reset value", rd, rval[i]);
        end
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("reset and unmapped done");
        tally_and_finish();
    end
endmodule : stc_top_tb
`default_nettype wire
